// File: verilog/exception_return_unstacker.sv
// Purpose: Exception return detection, validation and frame unstacking
// Assumes: Core, memory port and AHB-Lite all run on clock
// Notes:   Reads take one wait state, writes none
`timescale 1ns/1ps
`default_nettype none
module exception_return_unstacker (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        pc_load_valid,
	input  wire logic        pc_load_returnable,
	input  wire logic [31:0] pc_load_value,
	input  wire logic        wake_event,
	output logic             busy,
	output logic             mem_req,
	output logic [31:0]      mem_addr,
	output logic             mem_unpriv,
	input  wire logic        mem_ready,
	input  wire logic        mem_fault,
	input  wire logic [31:0] mem_rdata,
	output logic             restore_valid,
	output logic [2:0]       restore_index,
	output logic [31:0]      restore_data,
	output logic             jump_valid,
	output logic [31:0]      jump_target,
	output logic             sync_barrier,
	output logic             lockup,
	output logic             hard_fault_pending,
	output logic             event_flag,
	output logic             sleep_after_return
);

	typedef struct packed {
		unstack_pkg::fsm_type st;
		logic [2:0]  idx;
		logic [31:0] code;
		logic        use_process;
		logic        to_handler;
		logic [31:0] popped;
		logic [31:0] main_sp;
		logic [31:0] process_sp;
		logic [63:0] active;
		logic [31:0] status_word;
		logic        handler_mode;
		logic        stack_select;
		logic        unpriv;
		logic        sleep_en;
		logic        priority_mask_bit;
		logic        lockup;
		logic        hf_pend;
		logic        event_reg;
		logic        sleeping;
		logic        mem_req;
		logic [31:0] mem_addr;
		logic        mem_unpriv;
		logic        restore_valid;
		logic [2:0]  restore_index;
		logic [31:0] restore_data;
		logic        jump_valid;
		logic [31:0] jump_target;
		logic        barrier;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic        rd_pend;
		logic        rd_done;
		logic [7:0]  rd_addr;
		logic [31:0] hrdata;
	} unstack_state_type;

	unstack_state_type s_q;
	unstack_state_type s_d;

	logic        code_ok;
	logic        to_handler;
	logic        use_process;
	logic        addr_phase;
	logic [31:0] read_mux;
	logic [31:0] frame_ptr;
	logic [31:0] next_sp;
	logic [5:0]  next_num;
	logic        force_thread;
	logic        set_hf;
	logic        set_event;
	logic        set_sleep;

	return_code_decoder decoder (
		.code          (s_q.code),
		.active        (s_q.active),
		.returning_num (s_q.status_word[unstack_pkg::psr_num_hi:0]),
		.code_ok       (code_ok),
		.to_handler    (to_handler),
		.use_process   (use_process)
	);

	assign hreadyout = !(s_q.rd_pend && !s_q.rd_done);
	assign hresp     = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;
	assign frame_ptr = s_q.use_process ? s_q.process_sp : s_q.main_sp;
	assign next_sp   = (frame_ptr + unstack_pkg::frame_size) |
		{29'h0, s_q.popped[unstack_pkg::psr_align_bit], 2'b00};
	assign force_thread = !s_q.to_handler && s_q.unpriv;
	assign next_num  = force_thread ? 6'h00 : s_q.popped[unstack_pkg::psr_num_hi:0];

	always_comb begin
		case (s_q.rd_addr)
			unstack_pkg::ctrl_offset: read_mux = {27'h0, s_q.priority_mask_bit, s_q.handler_mode,
				s_q.sleep_en, s_q.stack_select, s_q.unpriv};
			unstack_pkg::status_offset: read_mux = {27'h0, s_q.sleeping, s_q.event_reg,
				s_q.hf_pend, s_q.lockup, (s_q.st != unstack_pkg::st_idle)};
			unstack_pkg::main_sp_offset:     read_mux = s_q.main_sp;
			unstack_pkg::process_sp_offset:  read_mux = s_q.process_sp;
			unstack_pkg::active_lo_offset:   read_mux = s_q.active[31:0];
			unstack_pkg::active_hi_offset:   read_mux = s_q.active[63:32];
			unstack_pkg::status_word_offset: read_mux = s_q.status_word;
			unstack_pkg::last_code_offset:   read_mux = s_q.code;
			default:                         read_mux = 32'h0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		set_hf = 1'b0;
		set_event = 1'b0;
		set_sleep = 1'b0;
		s_d.restore_valid = 1'b0;
		s_d.jump_valid = 1'b0;
		s_d.barrier = 1'b0;

		// Bus read data phase
		if (s_q.rd_pend && !s_q.rd_done) begin
			s_d.hrdata = read_mux;
			s_d.rd_done = 1'b1;
		end else if (s_q.rd_done) begin
			s_d.rd_pend = 1'b0;
			s_d.rd_done = 1'b0;
		end
		// Bus write data phase
		if (s_q.wr_pend) begin
			s_d.wr_pend = 1'b0;
			case (s_q.wr_addr)
				unstack_pkg::ctrl_offset: begin
					s_d.unpriv       = hwdata[unstack_pkg::ctrl_unpriv_bit];
					s_d.stack_select = hwdata[unstack_pkg::ctrl_stack_bit];
					s_d.sleep_en     = hwdata[unstack_pkg::ctrl_sleep_bit];
					s_d.handler_mode = hwdata[unstack_pkg::ctrl_handler_bit];
					s_d.priority_mask_bit      = hwdata[unstack_pkg::ctrl_priority_mask_bit_bit];
				end
				unstack_pkg::status_offset: begin
					if (hwdata[unstack_pkg::status_hfpend_bit]) begin
						s_d.hf_pend = 1'b0;
					end
					if (hwdata[unstack_pkg::status_event_bit]) begin
						s_d.event_reg = 1'b0;
					end
					if (hwdata[unstack_pkg::status_sleep_bit]) begin
						s_d.sleeping = 1'b0;
					end
				end
				unstack_pkg::main_sp_offset:     s_d.main_sp = hwdata;
				unstack_pkg::process_sp_offset:  s_d.process_sp = hwdata;
				unstack_pkg::active_lo_offset:   s_d.active[31:0] = hwdata;
				unstack_pkg::active_hi_offset:   s_d.active[63:32] = hwdata;
				unstack_pkg::status_word_offset: s_d.status_word = hwdata;
				default: begin
				end
			endcase
		end
		// Bus address phase
		if (addr_phase) begin
			if (hwrite) begin
				s_d.wr_pend = 1'b1;
				s_d.wr_addr = haddr[7:0];
			end else begin
				s_d.rd_pend = 1'b1;
				s_d.rd_done = 1'b0;
				s_d.rd_addr = haddr[7:0];
			end
		end
		if (wake_event) begin
			s_d.sleeping = 1'b0;
		end

		case (s_q.st)
			unstack_pkg::st_idle: begin
				if (pc_load_valid && !s_q.lockup) begin
					if (s_q.handler_mode && pc_load_returnable &&
						pc_load_value[31:28] == unstack_pkg::return_marker) begin
						s_d.code = pc_load_value;
						s_d.st = unstack_pkg::st_check;
					end else begin
						s_d.jump_valid = 1'b1;
						s_d.jump_target = pc_load_value;
						if (pc_load_value[31:28] == unstack_pkg::return_marker) begin
							set_hf = 1'b1;
						end
					end
				end
			end
			unstack_pkg::st_check: begin
				if (code_ok) begin
					s_d.active[s_q.status_word[unstack_pkg::psr_num_hi:0]] = 1'b0;
					s_d.to_handler = to_handler;
					s_d.use_process = use_process;
					s_d.handler_mode = to_handler;
					s_d.stack_select = use_process;
					s_d.idx = 3'h0;
					s_d.st = unstack_pkg::st_pop;
				end else begin
					set_hf = 1'b1;
					s_d.st = unstack_pkg::st_idle;
				end
			end
			unstack_pkg::st_pop: begin
				s_d.mem_req = 1'b1;
				s_d.mem_addr = frame_ptr + {27'h0, s_q.idx, 2'b00};
				s_d.mem_unpriv = !s_q.to_handler && s_q.unpriv;
				if (s_q.mem_req && mem_ready) begin
					s_d.mem_req = 1'b0;
					if (mem_fault) begin
						if (s_q.use_process) begin
							set_hf = 1'b1;
						end else begin
							s_d.lockup = 1'b1;
						end
						s_d.st = unstack_pkg::st_idle;
					end else if (s_q.idx == unstack_pkg::frame_status_slot) begin
						s_d.popped = mem_rdata;
						s_d.st = unstack_pkg::st_finish;
					end else begin
						s_d.restore_valid = 1'b1;
						s_d.restore_index = s_q.idx;
						s_d.restore_data = mem_rdata;
						s_d.idx = s_q.idx + 3'h1;
					end
				end
			end
			unstack_pkg::st_finish: begin
				if (s_q.use_process) begin
					s_d.process_sp = next_sp;
				end else begin
					s_d.main_sp = next_sp;
				end
				s_d.status_word = {s_q.popped[unstack_pkg::psr_flags_hi:unstack_pkg::psr_flags_lo],
					3'h0, s_q.popped[unstack_pkg::psr_exec_bit], 18'h0, next_num};
				if ((s_q.to_handler && next_num == 6'h00) ||
					(!s_q.to_handler && next_num != 6'h00)) begin
					set_hf = 1'b1;
				end
				set_event = 1'b1;
				s_d.barrier = 1'b1;
				set_sleep = !s_q.to_handler && s_q.sleep_en;
				s_d.st = unstack_pkg::st_idle;
			end
			default: begin
				s_d.st = unstack_pkg::st_idle;
			end
		endcase

		// Hardware set wins over software clear
		if (set_hf) begin
			s_d.hf_pend = 1'b1;
		end
		if (set_event) begin
			s_d.event_reg = 1'b1;
		end
		if (set_sleep) begin
			s_d.sleeping = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= unstack_pkg::st_idle;
			s_q.main_sp <= unstack_pkg::sp_reset;
			s_q.process_sp <= unstack_pkg::sp_reset;
			s_q.active <= unstack_pkg::active_reset;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata             = s_q.hrdata;
	assign busy               = (s_q.st != unstack_pkg::st_idle) || s_q.lockup;
	assign mem_req            = s_q.mem_req;
	assign mem_addr           = s_q.mem_addr;
	assign mem_unpriv         = s_q.mem_unpriv;
	assign restore_valid      = s_q.restore_valid;
	assign restore_index      = s_q.restore_index;
	assign restore_data       = s_q.restore_data;
	assign jump_valid         = s_q.jump_valid;
	assign jump_target        = s_q.jump_target;
	assign sync_barrier       = s_q.barrier;
	assign lockup             = s_q.lockup;
	assign hard_fault_pending = s_q.hf_pend;
	assign event_flag         = s_q.event_reg;
	assign sleep_after_return = s_q.sleeping;

endmodule : exception_return_unstacker
`default_nettype wire

// File: verilog/unstack_pkg.sv
// Purpose: Shared constants and types for the exception return unstacker
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes:   Offsets are byte addresses
package unstack_pkg;

	// Register byte offsets
	localparam logic [7:0] ctrl_offset       = 8'h00;
	localparam logic [7:0] status_offset     = 8'h04;
	localparam logic [7:0] main_sp_offset    = 8'h08;
	localparam logic [7:0] process_sp_offset = 8'h0c;
	localparam logic [7:0] active_lo_offset  = 8'h10;
	localparam logic [7:0] active_hi_offset  = 8'h14;
	localparam logic [7:0] status_word_offset = 8'h18;
	localparam logic [7:0] last_code_offset  = 8'h1c;

	// Control register fields
	localparam int ctrl_unpriv_bit   = 0;
	localparam int ctrl_stack_bit    = 1;
	localparam int ctrl_sleep_bit    = 2;
	localparam int ctrl_handler_bit  = 3;
	localparam int ctrl_priority_mask_bit_bit  = 4;

	// Status register fields
	localparam int status_busy_bit   = 0;
	localparam int status_lockup_bit = 1;
	localparam int status_hfpend_bit = 2;
	localparam int status_event_bit  = 3;
	localparam int status_sleep_bit  = 4;

	// Combined status word fields
	localparam int psr_flags_hi      = 31;
	localparam int psr_flags_lo      = 28;
	localparam int psr_exec_bit      = 24;
	localparam int psr_align_bit     = 9;
	localparam int psr_num_hi        = 5;

	// Return code layout
	localparam logic [3:0]  return_marker     = 4'hf;
	localparam logic [23:0] reserved_ones     = 24'hffffff;
	localparam logic [3:0]  code_handler_main = 4'h1;
	localparam logic [3:0]  code_thread_main  = 4'h9;
	localparam logic [3:0]  code_thread_proc  = 4'hd;

	// Frame layout
	localparam logic [31:0] frame_size        = 32'h0000_0020;
	localparam logic [2:0]  frame_status_slot = 3'h7;

	// Reset values
	localparam logic [31:0] sp_reset          = 32'h0000_0000;
	localparam logic [63:0] active_reset      = 64'h0;

	typedef enum logic [1:0] {
		st_idle   = 2'b00,
		st_check  = 2'b01,
		st_pop    = 2'b10,
		st_finish = 2'b11
	} fsm_type;

endpackage : unstack_pkg

// File: verilog/return_code_decoder.sv
// Purpose: Classifies an exception return code against the active set
// Assumes: Purely combinational, same clock domain as its user
// Notes:   Counts active flags only as none, one or several
`timescale 1ns/1ps
`default_nettype none
module return_code_decoder (
	input  wire logic [31:0] code,
	input  wire logic [63:0] active,
	input  wire logic [5:0]  returning_num,
	output logic             code_ok,
	output logic             to_handler,
	output logic             use_process
);

	logic        field_ok;
	logic        returning_active;
	logic        several;
	logic        exactly_one;
	logic [63:0] active_less_one;

	assign field_ok         = (code[27:4] == unstack_pkg::reserved_ones);
	assign returning_active = active[returning_num];
	assign active_less_one  = active - 64'h1;
	assign several          = |(active & active_less_one);
	assign exactly_one      = (active != 64'h0) && !several;
	assign to_handler       = (code[3:0] == unstack_pkg::code_handler_main);
	assign use_process      = (code[3:0] == unstack_pkg::code_thread_proc);

	always_comb begin
		case (code[3:0])
			unstack_pkg::code_handler_main: code_ok = several;
			unstack_pkg::code_thread_main:  code_ok = exactly_one;
			unstack_pkg::code_thread_proc:  code_ok = exactly_one;
			default:                        code_ok = 1'b0;
		endcase
		code_ok = code_ok && field_ok && returning_active;
	end

endmodule : return_code_decoder
`default_nettype wire

// File: tb/unstack_mem_model.sv
// Purpose: Stack memory model holding one exception frame
// Assumes: Registered answer after an optional stall
// Notes:   Idle read data toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module unstack_mem_model (
	input wire logic	clock,
	input wire logic	mem_req,
	input wire logic [31:0]	mem_addr,
	input wire logic [1:0]	stall,
	input wire logic [3:0]	fault_word,
	input wire logic [31:0]	psr_word,
	output logic		mem_ready,
	output logic		mem_fault,
	output logic [31:0]	mem_rdata
);
	logic [1:0]	wait_q;
	initial begin
		mem_ready = 1'b0;
		mem_fault = 1'b0;
		mem_rdata = 32'h0;
		wait_q = 2'h0;
	end
	always @(posedge clock) begin
		if (mem_req && !mem_ready && wait_q >= stall) begin
			mem_ready <= 1'b1;
			mem_fault <= {1'b0, mem_addr[4:2]} == fault_word;
			mem_rdata <= mem_addr[4:2] == 3'h7 ? psr_word : mem_addr ^ 32'h5a00_0000;
			wait_q <= 2'h0;
		end else begin
			mem_ready <= 1'b0;
			mem_fault <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_q <= mem_req ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule : unstack_mem_model
`default_nettype wire

// File: tb/exception_return_unstacker_asserts.sv
// Purpose: Port assertions for the exception return unstacker
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module exception_return_unstacker_asserts (
	input wire logic	clock,
	input wire logic	sys_rst,
	input wire logic	pc_load_valid,
	input wire logic [31:0]	pc_load_value,
	input wire logic	busy,
	input wire logic	mem_req,
	input wire logic [31:0]	mem_addr,
	input wire logic	mem_ready,
	input wire logic	mem_fault,
	input wire logic	restore_valid,
	input wire logic [2:0]	restore_index,
	input wire logic	jump_valid,
	input wire logic	sync_barrier,
	input wire logic	lockup,
	input wire logic	hard_fault_pending
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Frame words accepted in the current return
	logic [2:0]	word_q;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			word_q <= 3'h0;
		end else if (mem_req && mem_ready) begin
			word_q <= mem_fault ? 3'h0 : word_q + 3'h1;
		end
	end
	sequence taken;
		mem_req && mem_ready;
	endsequence
	sequence word_ok;
		taken ##0 (!mem_fault && word_q != 3'h7);
	endsequence
	chk_pop_step: assert property (
		word_ok |=> restore_valid && restore_index == $past(word_q))
		else $error("restore does not follow frame word");
	chk_addr_step: assert property (
		word_ok |=> !mem_req ##1 (mem_req && mem_addr == $past(mem_addr, 2) + 32'h4))
		else $error("frame address not ascending");
	chk_req_hold: assert property (
		mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
		else $error("request dropped before answer");
	chk_finish_sync: assert property (
		taken ##0 (!mem_fault && word_q == 3'h7) |-> ##[1:4] sync_barrier)
		else $error("no barrier after last word");
	chk_fault_stop: assert property (
		taken ##0 mem_fault |=> !mem_req [*3])
		else $error("unstacking goes on after fault");
	chk_fault_flag: assert property (
		taken ##0 mem_fault |-> ##[1:3] (lockup || hard_fault_pending))
		else $error("fault not reported");
	chk_lock_holds: assert property (
		lockup |=> lockup && busy && !mem_req)
		else $error("lockup left or engine active");
	chk_jump_now: assert property (
		pc_load_valid && !busy && pc_load_value[31:28] != 4'hf |=> jump_valid && !mem_req)
		else $error("plain load not a jump");
endmodule : exception_return_unstacker_asserts
bind exception_return_unstacker exception_return_unstacker_asserts chk_i (.clock, .sys_rst,
	.pc_load_valid, .pc_load_value, .busy, .mem_req, .mem_addr, .mem_ready, .mem_fault,
	.restore_valid, .restore_index, .jump_valid, .sync_barrier, .lockup, .hard_fault_pending);
`default_nettype wire

// File: tb/exception_return_unstacker_tb.sv
// Purpose: Self-checking bench for the exception return unstacker
// Assumes: Frame reads answered by the memory model
// Notes:   Registers reached over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module exception_return_unstacker_tb;
	logic		clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, busy, mem_req;
	logic		pc_load_valid, pc_load_returnable, wake_event, mem_unpriv, mem_ready;
	logic		mem_fault, restore_valid, jump_valid, sync_barrier, lockup;
	logic		hard_fault_pending, event_flag, sleep_after_return;
	logic [1:0]	htrans, stall;
	logic [2:0]	hsize, restore_index;
	logic [3:0]	fault_word;
	logic [31:0]	haddr, hwdata, hrdata, pc_load_value, mem_addr, mem_rdata;
	logic [31:0]	restore_data, jump_target, psr_word;
	int		err_count, comparisons;
	assign hready = hreadyout;
	exception_return_unstacker dut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pc_load_valid,
		.pc_load_returnable, .pc_load_value, .wake_event, .busy, .mem_req, .mem_addr,
		.mem_unpriv, .mem_ready, .mem_fault, .mem_rdata, .restore_valid, .restore_index,
		.restore_data, .jump_valid, .jump_target, .sync_barrier, .lockup,
		.hard_fault_pending, .event_flag, .sleep_after_return);
	unstack_mem_model mem (.clock, .mem_req, .mem_addr, .stall, .fault_word, .psr_word,
		.mem_ready, .mem_fault, .mem_rdata);
	task automatic end_sim;
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic guard(input int n);
		if (n >= 200) begin
			err_count++;
			end_sim;
		end
	endtask : guard
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(negedge clock); while (!hreadyout && ++n < 200);
		@(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(negedge clock); while (!hreadyout && ++n < 200);
		r = hrdata;
		chk(32'(hresp), 32'h0);
		@(posedge clock);
		guard(n);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask : rd_chk
	task automatic arm(input logic [31:0] c, input logic [31:0] a, input logic [31:0] p,
		input logic [31:0] m, input logic [31:0] s);
		wr(8'h00, c);
		wr(8'h10, a);
		wr(8'h18, p);
		wr(8'h08, m);
		wr(8'h0c, s);
	endtask : arm
	task automatic fire(input logic [31:0] code, input logic ret, input logic [31:0] sp,
		input logic up, input int words, input logic [1:0] e);
		int n, k, j, s;
		n = 0;
		k = 0;
		j = 0;
		s = 0;
		pc_load_valid <= 1'b1;
		pc_load_returnable <= ret;
		pc_load_value <= code;
		@(posedge clock);
		pc_load_valid <= 1'b0;
		do begin
			@(negedge clock);
			n++;
			if (mem_req) chk(32'(mem_unpriv), 32'(up));
			if (jump_valid) chk(jump_target, code);
			j += 32'(jump_valid);
			s += 32'(sync_barrier);
			if (restore_valid) begin
				chk({29'h0, restore_index}, k);
				chk(restore_data, (sp + 4 * k) ^ 32'h5a00_0000);
				k++;
			end
		end while ((busy || n < 4) && !lockup && n < 200);
		@(posedge clock);
		guard(n);
		chk(k, words);
		chk(j, 32'(e[1]));
		chk(s, 32'(e[0]));
	endtask : fire
	task automatic sc_thread_main;
		psr_word <= 32'hb100_0200;
		arm(32'h18, 32'h08, 32'h03, 32'h1000, 32'h0);
		fire(32'hffff_fff9, 1'b1, 32'h1000, 1'b0, 7, 2'b01);
		chk(32'(event_flag), 32'h1);
		rd_chk(8'h08, 32'h1024);
		rd_chk(8'h00, 32'h10);
		rd_chk(8'h10, 32'h0);
		rd_chk(8'h18, 32'hb100_0000);
		rd_chk(8'h04, 32'h08);
		wr(8'h04, 32'h08);
	endtask : sc_thread_main
	task automatic sc_thread_proc;
		psr_word <= 32'h4000_0005;
		arm(32'h0d, 32'h20, 32'h05, 32'h0, 32'h2000);
		fire(32'hffff_fffd, 1'b1, 32'h2000, 1'b1, 7, 2'b01);
		rd_chk(8'h0c, 32'h2020);
		rd_chk(8'h00, 32'h07);
		rd_chk(8'h18, 32'h4000_0000);
		chk(32'(sleep_after_return), 32'h1);
		rd_chk(8'h04, 32'h18);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
		@(negedge clock);
		chk(32'(sleep_after_return), 32'h0);
		@(posedge clock);
		wr(8'h04, 32'h18);
	endtask : sc_thread_proc
	task automatic sc_handler_main;
		stall <= 2'h2;
		psr_word <= 32'h0000_0002;
		arm(32'h08, 32'h84, 32'h07, 32'h3000, 32'h0);
		fire(32'hffff_fff1, 1'b1, 32'h3000, 1'b0, 7, 2'b01);
		rd_chk(8'h00, 32'h08);
		rd_chk(8'h10, 32'h04);
		rd_chk(8'h18, 32'h02);
		rd_chk(8'h08, 32'h3020);
		rd_chk(8'h04, 32'h08);
		wr(8'h04, 32'h08);
		stall <= 2'h0;
	endtask : sc_handler_main
	task automatic sc_bad_codes;
		logic [31:0] bad [4] = '{32'hffff_fff1, 32'hfff0_fff9, 32'hffff_fff5, 32'hffff_fff9};
		for (int i = 0; i < 4; i++) begin
			arm(32'h08, 32'h04, i == 3 ? 32'h03 : 32'h02, 32'h3000, 32'h0);
			fire(bad[i], 1'b1, 32'h3000, 1'b0, 0, 2'b00);
			rd_chk(8'h10, 32'h04);
			rd_chk(8'h04, 32'h04);
			wr(8'h04, 32'h04);
		end
	endtask : sc_bad_codes
	task automatic sc_jumps;
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, i == 2 ? 32'h0 : 32'h08);
			fire(i == 0 ? 32'h1234 : 32'hffff_fff9, i != 1, 32'h0, 1'b0, 0, 2'b10);
			rd_chk(8'h04, i == 0 ? 32'h0 : 32'h04);
			wr(8'h04, 32'h04);
		end
	endtask : sc_jumps
	task automatic sc_mismatch;
		psr_word <= 32'h0000_0004;
		arm(32'h08, 32'h08, 32'h03, 32'h1000, 32'h0);
		fire(32'hffff_fff9, 1'b1, 32'h1000, 1'b0, 7, 2'b01);
		rd_chk(8'h04, 32'h0c);
		rd_chk(8'h18, 32'h04);
		rd_chk(8'h08, 32'h1020);
		wr(8'h04, 32'h0c);
	endtask : sc_mismatch
	task automatic sc_faults;
		fault_word <= 4'h7;
		for (int i = 0; i < 2; i++) begin
			arm(32'h08, 32'h08, 32'h03, 32'h1000, 32'h2000);
			fire(i ? 32'hffff_fff9 : 32'hffff_fffd, 1'b1, i ? 32'h1000 : 32'h2000,
				1'b0, 7, 2'b00);
			chk(32'(lockup), 32'(i));
			chk(32'(hard_fault_pending), 32'(i == 0));
			rd_chk(8'h04, i ? 32'h02 : 32'h04);
			rd_chk(i ? 8'h08 : 8'h0c, i ? 32'h1000 : 32'h2000);
			wr(8'h04, 32'h04);
		end
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd_chk(8'h04, 32'h0);
		chk(32'(lockup), 32'h0);
	endtask : sc_faults
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		{hsel, hwrite, pc_load_valid, pc_load_returnable, wake_event} = 5'h0;
		{haddr, hwdata, pc_load_value, psr_word} = 128'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		stall = 2'h0;
		fault_word = 4'hf;
		err_count = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		sc_thread_main;
		sc_thread_proc;
		sc_handler_main;
		sc_bad_codes;
		sc_jumps;
		sc_mismatch;
		sc_faults;
		end_sim;
	end
endmodule : exception_return_unstacker_tb
`default_nettype wire
